/* File: mailbox_pkg.sv */
// Purpose: constants shared by the dual core mailbox
// Assumes: 32-bit AXI4-Lite register bus, byte addresses
// Notes: offsets are byte addresses of aligned words
package mailbox_pkg;
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFF_A_PEND = 12'h000;
  localparam logic [11:0] OFF_A_RAISE = 12'h004;
  localparam logic [11:0] OFF_A_DROP = 12'h008;
  localparam logic [11:0] OFF_B_PEND = 12'h010;
  localparam logic [11:0] OFF_B_RAISE = 12'h014;
  localparam logic [11:0] OFF_B_DROP = 12'h018;
  localparam logic [11:0] OFF_EVT_STAT = 12'h020;
  localparam logic [11:0] OFF_EVT_MASK = 12'h024;
  localparam logic [11:0] OFF_LOCK = 12'h0f8;
  localparam int LOCK_BIT = 0;
  localparam logic [31:0] PEND_RST = 32'h0000_0000;
  localparam logic LOCK_RST = 1'b1;
  localparam logic [1:0] EVT_RST = 2'h0;
  localparam int EVT_A_BIT = 0;
  localparam int EVT_B_BIT = 1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: req_bank.sv */
// Purpose: one core's request register with set and clear ports
// Assumes: write strobes are one-cycle pulses
// Notes: direct write, set and clear are mutually exclusive per cycle
`timescale 1ns/1ps
module req_bank
  import mailbox_pkg::*;
#(
  parameter int WIDTH = 32
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic wr_direct,
  input wire logic wr_raise,
  input wire logic wr_drop,
  input wire logic [WIDTH-1:0] wdata,
  output logic [WIDTH-1:0] pend,
  output logic irq
);
  typedef struct packed {
    logic [WIDTH-1:0] pend;
    logic irq;
  } bank_t;
  bank_t st_ff;
  bank_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (wr_direct) begin
      nxt_st.pend = wdata;
    end else if (wr_raise) begin
      nxt_st.pend = st_ff.pend | wdata;
    end else if (wr_drop) begin
      nxt_st.pend = st_ff.pend & ~wdata;
    end
    nxt_st.irq = |nxt_st.pend;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= '{pend: PEND_RST[WIDTH-1:0], irq: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pend = st_ff.pend;
  assign irq = st_ff.irq;
endmodule

/* File: dual_core_mailbox.sv */
// Purpose: inter-processor mailbox with request banks and a hardware lock
// Assumes: AXI4-Lite slave, one write and one read in flight at most
// Notes: lock read-clear and write-set are arbitrated to one per cycle
`timescale 1ns/1ps
// How it works
// - Each of the two cores has 32 independent request bits that the other core can raise.
// - Core A's interrupt is high whenever any bit of its request register is one.
// - Core A's request register sits at 0x000, readable, writable, reset to zero.
// - Core B's request register sits at 0x010, readable, writable, reset to zero, driving B's interrupt.
// - Writing 0x004 sets every core A request bit that holds a one in the data.
// - Writing 0x008 clears every core A request bit that holds a one in the data.
// - Writing 0x014 sets every core B request bit that holds a one in the data.
// - Writing 0x018 clears every core B request bit that holds a one in the data.
// - A read of the lock at 0x0F8 returns the lock bit and then clears it.
// - A write to the lock sets the lock bit whatever the data, unless a lock read in the same cycle clears it.
// - The lock flag is bit 0, resets to one, and bits 31:1 are reserved.
module dual_core_mailbox
  import mailbox_pkg::*;
#(
  parameter int NUM_REQ = 32
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic core_a_irq,
  output logic core_b_irq,
  output logic mbox_irq
);
  typedef struct packed {
    logic aw_held;
    logic aw_ready;
    logic [ADDR_W-1:0] awaddr;
    logic w_held;
    logic w_ready;
    logic [31:0] wdata;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic ar_ready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic lock_flag;
    logic [1:0] evt_stat;
    logic [1:0] evt_mask;
    logic mbox_irq;
  } mbox_t;

  mbox_t st_ff;
  mbox_t nxt_st;

  logic do_write;
  logic [ADDR_W-1:0] wr_addr;
  logic wr_a_direct;
  logic wr_a_raise;
  logic wr_a_drop;
  logic wr_b_direct;
  logic wr_b_raise;
  logic wr_b_drop;
  logic [NUM_REQ-1:0] a_pend;
  logic [NUM_REQ-1:0] b_pend;
  logic a_irq_ff;
  logic b_irq_ff;
  logic do_read;
  logic lock_wr;
  logic lock_rd;

  // write fires once both address and data are held and the response slot is free
  assign do_write = st_ff.aw_held && st_ff.w_held && !st_ff.bvalid;
  assign wr_addr = {st_ff.awaddr[ADDR_W-1:2], 2'b00};
  assign wr_a_direct = do_write && (wr_addr == OFF_A_PEND);
  assign wr_a_raise = do_write && (wr_addr == OFF_A_RAISE);
  assign wr_a_drop = do_write && (wr_addr == OFF_A_DROP);
  assign wr_b_direct = do_write && (wr_addr == OFF_B_PEND);
  assign wr_b_raise = do_write && (wr_addr == OFF_B_RAISE);
  assign wr_b_drop = do_write && (wr_addr == OFF_B_DROP);
  // a read is taken when nothing waits on the read channel
  assign do_read = s_axi_arvalid && st_ff.ar_ready;
  assign lock_wr = do_write && (wr_addr == OFF_LOCK);
  assign lock_rd = do_read && ({s_axi_araddr[ADDR_W-1:2], 2'b00} == OFF_LOCK);

  req_bank #(
    .WIDTH(NUM_REQ)
  ) u_bank_a (
    .aclk(aclk),
    .aresetn(aresetn),
    .wr_direct(wr_a_direct),
    .wr_raise(wr_a_raise),
    .wr_drop(wr_a_drop),
    .wdata(st_ff.wdata[NUM_REQ-1:0]),
    .pend(a_pend),
    .irq(a_irq_ff)
  );

  req_bank #(
    .WIDTH(NUM_REQ)
  ) u_bank_b (
    .aclk(aclk),
    .aresetn(aresetn),
    .wr_direct(wr_b_direct),
    .wr_raise(wr_b_raise),
    .wr_drop(wr_b_drop),
    .wdata(st_ff.wdata[NUM_REQ-1:0]),
    .pend(b_pend),
    .irq(b_irq_ff)
  );

  always_comb begin
    logic [31:0] rd_val;
    logic [ADDR_W-1:0] rd_addr;
    logic [1:0] evt_set;
    rd_val = 32'h0000_0000;
    rd_addr = {s_axi_araddr[ADDR_W-1:2], 2'b00};
    evt_set = 2'h0;
    nxt_st = st_ff;

    if (s_axi_awvalid && st_ff.aw_ready) begin
      nxt_st.aw_held = 1'b1;
      nxt_st.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_ff.w_ready) begin
      nxt_st.w_held = 1'b1;
      nxt_st.wdata = s_axi_wdata;
    end

    if (do_write) begin
      nxt_st.aw_held = 1'b0;
      nxt_st.w_held = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = RESP_OKAY;
      case (wr_addr)
        OFF_A_PEND, OFF_A_RAISE, OFF_A_DROP, OFF_B_PEND, OFF_B_RAISE, OFF_B_DROP,
        OFF_LOCK: begin
        end
        OFF_EVT_STAT: begin
          nxt_st.evt_stat = st_ff.evt_stat & ~st_ff.wdata[1:0];
        end
        OFF_EVT_MASK: begin
          nxt_st.evt_mask = st_ff.wdata[1:0];
        end
        default: begin
          nxt_st.bresp = RESP_SLVERR;
        end
      endcase
      // raising a request counts as an event for that core
      evt_set[EVT_A_BIT] = (wr_a_raise || wr_a_direct) && (|st_ff.wdata[NUM_REQ-1:0]);
      evt_set[EVT_B_BIT] = (wr_b_raise || wr_b_direct) && (|st_ff.wdata[NUM_REQ-1:0]);
    end
    if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
    end

    // lock: read-clear and write-set resolved once per cycle, reads on a single port
    if (lock_wr) begin
      nxt_st.lock_flag = 1'b1;
    end
    if (lock_rd) begin
      nxt_st.lock_flag = 1'b0;
    end

    if (do_read) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp = RESP_OKAY;
      case (rd_addr)
        OFF_A_PEND: rd_val = a_pend;
        OFF_B_PEND: rd_val = b_pend;
        OFF_A_RAISE, OFF_A_DROP, OFF_B_RAISE, OFF_B_DROP: rd_val = 32'h0000_0000;
        OFF_EVT_STAT: rd_val = {30'h0000_0000, st_ff.evt_stat};
        OFF_EVT_MASK: rd_val = {30'h0000_0000, st_ff.evt_mask};
        OFF_LOCK: rd_val = {31'h0000_0000, st_ff.lock_flag};
        default: begin
          rd_val = 32'h0000_0000;
          nxt_st.rresp = RESP_SLVERR;
        end
      endcase
      nxt_st.rdata = rd_val;
    end else if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end

    // set wins over a clear in the same cycle
    nxt_st.evt_stat = nxt_st.evt_stat | evt_set;
    nxt_st.mbox_irq = |(nxt_st.evt_stat & nxt_st.evt_mask);

    // readies are registered; a pending write answer blocks the next write
    nxt_st.aw_ready = !nxt_st.aw_held && !nxt_st.bvalid;
    nxt_st.w_ready = !nxt_st.w_held && !nxt_st.bvalid;
    nxt_st.ar_ready = !nxt_st.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= '{
        aw_held: 1'b0,
        aw_ready: 1'b1,
        awaddr: '0,
        w_held: 1'b0,
        w_ready: 1'b1,
        wdata: 32'h0000_0000,
        bvalid: 1'b0,
        bresp: RESP_OKAY,
        rvalid: 1'b0,
        ar_ready: 1'b1,
        rdata: 32'h0000_0000,
        rresp: RESP_OKAY,
        lock_flag: LOCK_RST,
        evt_stat: EVT_RST,
        evt_mask: EVT_RST,
        mbox_irq: 1'b0
      };
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign s_axi_awready = st_ff.aw_ready;
  assign s_axi_wready = st_ff.w_ready;
  assign s_axi_bvalid = st_ff.bvalid;
  assign s_axi_bresp = st_ff.bresp;
  assign s_axi_arready = st_ff.ar_ready;
  assign s_axi_rvalid = st_ff.rvalid;
  assign s_axi_rdata = st_ff.rdata;
  assign s_axi_rresp = st_ff.rresp;
  assign core_a_irq = a_irq_ff;
  assign core_b_irq = b_irq_ff;
  assign mbox_irq = st_ff.mbox_irq;
endmodule

/* File: mailbox_props.sv */
// Purpose: bus timing and interrupt checks for the mailbox
// Assumes: sees only the top module ports
// Notes: one clock domain, synchronous reset
`timescale 1ns/1ps
module mailbox_props
  import mailbox_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic core_a_irq,
  input wire logic core_b_irq,
  input wire logic mbox_irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence rd_at(logic [11:0] a);
    s_axi_arvalid && s_axi_arready && s_axi_araddr == a;
  endsequence
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  a_write_answer: assert property (wr_take |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  a_one_write: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answering");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
    else $error("read data moved");
  a_irq_at_write: assert property (
    !$stable({core_a_irq, core_b_irq, mbox_irq}) |-> $rose(s_axi_bvalid))
    else $error("interrupt moved without a write");
  a_pend_a_irq: assert property (rd_at(OFF_A_PEND) |=> $rose(s_axi_bvalid) ||
    (|s_axi_rdata) == core_a_irq) else $error("core a interrupt mismatch");
  a_pend_b_irq: assert property (rd_at(OFF_B_PEND) |=> $rose(s_axi_bvalid) ||
    (|s_axi_rdata) == core_b_irq) else $error("core b interrupt mismatch");
  a_ports_zero: assert property (rd_at(OFF_A_RAISE) or rd_at(OFF_B_RAISE) |=>
    s_axi_rdata == 32'h0000_0000) else $error("raise port read not zero");
endmodule
bind dual_core_mailbox mailbox_props mailbox_props_i (.*);

/* File: core_irq_sink.sv */
// Purpose: stand-in for the interrupt inputs of the two cores
// Assumes: level interrupts sampled on aclk
// Notes: counts each rising request once
`timescale 1ns/1ps
module core_irq_sink (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic core_a_irq,
  input wire logic core_b_irq,
  output logic [7:0] hits_a,
  output logic [7:0] hits_b
);
  logic a_ff = 1'b0;
  logic b_ff = 1'b0;
  always @(posedge aclk) begin
    a_ff <= core_a_irq && aresetn;
    b_ff <= core_b_irq && aresetn;
    hits_a <= aresetn ? hits_a + 8'(core_a_irq && !a_ff) : 8'h00;
    hits_b <= aresetn ? hits_b + 8'(core_b_irq && !b_ff) : 8'h00;
  end
endmodule

/* File: dual_core_mailbox_tb.sv */
// Purpose: register level test of the dual core mailbox
// Assumes: one write or read in flight, bounded waits
// Notes: request banks, lock, events and unmapped space
`timescale 1ns/1ps
module dual_core_mailbox_tb import mailbox_pkg::*;;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic core_a_irq, core_b_irq, mbox_irq;
  logic [7:0] hits_a, hits_b;
  int n_fail = 0;
  int checked = 0;
  always #10 aclk = ~aclk;
  dual_core_mailbox dual_core_mailbox_i (.*);
  core_irq_sink core_irq_sink_i (.*);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("counts: %0d checked, %0d failed", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic expire(input int n);
    if (n >= 50) begin
      n_fail++;
      conclude();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 50);
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(er));
    expire(n);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      // late rready: the read data must stand through one stall cycle
      if (n == 2) s_axi_rready <= 1'b1;
    end while (!(s_axi_rvalid && s_axi_rready) && n < 50);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, exp);
    chk(32'(s_axi_rresp), 32'(er));
    expire(n);
  endtask
  initial begin
    logic [11:0] b;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      b = 12'(i * 16);
      rd(b, PEND_RST, RESP_OKAY);
      wr(b, 32'h8000_0001, RESP_OKAY);
      rd(b, 32'h8000_0001, RESP_OKAY);
      chk(32'(i ? core_b_irq : core_a_irq), 32'h0000_0001);
      wr(b + 12'h004, 32'h0000_0f00, RESP_OKAY);
      rd(b, 32'h8000_0f01, RESP_OKAY);
      wr(b + 12'h008, 32'h8000_0101, RESP_OKAY);
      rd(b, 32'h0000_0e00, RESP_OKAY);
      rd(b + 12'h004, 32'h0000_0000, RESP_OKAY);
      wr(b + 12'h008, 32'hffff_ffff, RESP_OKAY);
      chk(32'(i ? core_b_irq : core_a_irq), 32'h0000_0000);
      $display("request bank %0d done", i);
    end
    rd(OFF_LOCK, 32'h0000_0001, RESP_OKAY);
    rd(OFF_LOCK, 32'h0000_0000, RESP_OKAY);
    wr(OFF_LOCK, 32'h0000_0000, RESP_OKAY);
    rd(OFF_LOCK, 32'h0000_0001, RESP_OKAY);
    $display("lock done");
    rd(OFF_EVT_STAT, 32'h0000_0003, RESP_OKAY);
    wr(OFF_EVT_STAT, 32'h0000_0003, RESP_OKAY);
    wr(OFF_EVT_MASK, 32'h0000_0001, RESP_OKAY);
    chk(32'(mbox_irq), 32'h0000_0000);
    wr(OFF_A_RAISE, 32'h0000_0004, RESP_OKAY);
    chk(32'(mbox_irq), 32'h0000_0001);
    rd(OFF_EVT_STAT, 32'h0000_0001, RESP_OKAY);
    wr(OFF_EVT_MASK, 32'h0000_0000, RESP_OKAY);
    chk(32'(mbox_irq), 32'h0000_0000);
    wr(OFF_EVT_STAT, 32'h0000_0001, RESP_OKAY);
    rd(OFF_EVT_STAT, 32'h0000_0000, RESP_OKAY);
    rd(12'h100, 32'h0000_0000, RESP_SLVERR);
    wr(12'h100, 32'h0000_0001, RESP_SLVERR);
    chk(32'(hits_a), 32'h0000_0002);
    chk(32'(hits_b), 32'h0000_0001);
    $display("events and unmapped space done");
    conclude();
  end
endmodule
